// ==== inc/cac_pkg.sv ====
// cac_pkg: constants and types shared by the acquisition controller files.
// assumes one clock at 10 MHz; every duration is a count of its periods.
`default_nettype none
package cac_pkg;
  localparam int CAC_PIX_W = 12;
  localparam int CAC_OUT_W = 8;
  localparam int CAC_LUT_DEPTH = 4096;
  localparam int CAC_TIME_W = 24;
  localparam int CAC_LINE_W = 12;
  localparam int CAC_SLOT_N = 8;
  localparam int CAC_SLOT_W = 3;
  localparam int CAC_FIFO_DEPTH = 8;
  localparam int CAC_CLK_PERIOD_NS = 100;
  localparam int CAC_START_LAT_NS = 200;
  localparam int CAC_START_LAT_CYC =
    (CAC_START_LAT_NS + CAC_CLK_PERIOD_NS - 1) / CAC_CLK_PERIOD_NS;
  localparam logic [CAC_TIME_W-1:0] CAC_LAT_LOAD = CAC_TIME_W'(CAC_START_LAT_CYC - 1);
  localparam logic [CAC_TIME_W-1:0] CAC_EXPOSURE_RST = 24'h0003e8;
  localparam logic [CAC_TIME_W-1:0] CAC_DELAY_RST = 24'h000000;
  localparam logic [CAC_LINE_W-1:0] CAC_ROI_FIRST_RST = 12'h000;
  localparam logic [CAC_LINE_W-1:0] CAC_ROI_LAST_RST = 12'hfff;
  localparam logic [CAC_SLOT_W-1:0] CAC_BOOT_SLOT_RST = 3'h0;

  typedef enum logic [1:0] {CAC_MODE_FREE, CAC_MODE_TIMED, CAC_MODE_PULSE} cac_mode_t;

  typedef enum logic [2:0] {
    CAC_ST_IDLE,
    CAC_ST_ALIGN,
    CAC_ST_LATENCY,
    CAC_ST_EXPOSE,
    CAC_ST_DELAY,
    CAC_ST_WAIT_RD
  } cac_state_t;

  typedef struct packed {
    cac_mode_t mode;
    logic lut_en;
    logic roi_en;
    logic [CAC_TIME_W-1:0] exposure;
    logic [CAC_TIME_W-1:0] delay;
    logic [CAC_LINE_W-1:0] roi_first;
    logic [CAC_LINE_W-1:0] roi_last;
  } cac_cfg_t;

  localparam cac_cfg_t CAC_CFG_RST = '{
    mode: CAC_MODE_FREE,
    lut_en: 1'b0,
    roi_en: 1'b0,
    exposure: CAC_EXPOSURE_RST,
    delay: CAC_DELAY_RST,
    roi_first: CAC_ROI_FIRST_RST,
    roi_last: CAC_ROI_LAST_RST
  };
endpackage : cac_pkg
`default_nettype wire

// ==== logic/cac_fifo.sv ====
// cac_fifo: flip-flop fifo with valid/ready on both sides.
// assumes the same clock and clock enable as its parent.
`default_nettype none
module cac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  function automatic logic [AW-1:0] cac_ptr_inc(input logic [AW-1:0] p);
    cac_ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : cac_ptr_inc

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid && o_in_ready && i_ce;
  wire pop = o_out_valid && i_out_ready && i_ce;

  assign o_in_ready = (count != FULL_CNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= cac_ptr_inc(wr_ptr);
      if (pop)
        rd_ptr <= cac_ptr_inc(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  default clocking cb_fifo @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_fifo_no_overrun: assert property (count <= FULL_CNT)
    else $error("fifo count above depth");
  a_fifo_count_up: assert property (push && !pop |=> count == $past(count) + 1'b1)
    else $error("fifo count missed a push");
endmodule : cac_fifo
`default_nettype wire

// ==== logic/cac_top.sv ====
// cac_top: exposure sequencing, readout with region of interest, pixel
// remap table and stored configuration slots of an area-scan camera.
// assumes sensor data on i_clk in the cycle of o_sensor_read; trigger pin async.
// Summary of operation
// - remap each 12-bit pixel to 8 bits
// - table entry for every converter code
// - region of interest skips unselected lines
// - free run: continuous frames, line/frame strobes
// - free run exposure timed from host value
// - triggered mode idles until trigger arrives
// - pulse width: rising starts, falling ends exposure
// - exposure may change every frame
// - trigger during frame waits for line fall
// - trigger outside frame: fixed short latency
// - software trigger acts as hardware trigger, but runs timed in pulse mode
// - programmable delay before readout starts
// - all durations counted in clock periods
// - live settings reset to defaults
// - eight stored full configuration slots, loadable
// - power-up slot loaded automatically
// - store writes live settings to slot
`default_nettype none
module cac_top
  import cac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_trigger_pin,
  input wire logic i_soft_trigger,
  input wire logic i_cfg_write,
  input wire logic [1:0] i_mode,
  input wire logic i_lut_enable,
  input wire logic i_roi_enable,
  input wire logic [CAC_TIME_W-1:0] i_exposure,
  input wire logic [CAC_TIME_W-1:0] i_readout_delay,
  input wire logic [CAC_LINE_W-1:0] i_roi_first_line,
  input wire logic [CAC_LINE_W-1:0] i_roi_last_line,
  input wire logic [CAC_LINE_W-1:0] i_line_pixels,
  input wire logic [CAC_LINE_W-1:0] i_frame_lines,
  input wire logic i_lut_write,
  input wire logic [CAC_PIX_W-1:0] i_lut_addr,
  input wire logic [CAC_OUT_W-1:0] i_lut_data,
  input wire logic [CAC_SLOT_W-1:0] i_config_slot_selector,
  input wire logic i_config_slot_load_cmd,
  input wire logic i_config_slot_store_cmd,
  input wire logic [CAC_SLOT_W-1:0] i_default_slot,
  input wire logic [CAC_PIX_W-1:0] i_sensor_data,
  output logic o_sensor_read,
  output logic o_exposing,
  output logic o_line_valid_strobe,
  output logic o_frame_valid_strobe,
  output logic o_pix_valid,
  input wire logic i_pix_ready,
  output logic [CAC_OUT_W-1:0] o_pix_data,
  output logic [CAC_SLOT_W-1:0] o_boot_slot,
  output logic o_load_armed
);
  function automatic logic [CAC_TIME_W-1:0] cac_dec(input logic [CAC_TIME_W-1:0] v);
    cac_dec = (v == '0) ? '0 : v - 1'b1;
  endfunction : cac_dec

  function automatic logic [CAC_LINE_W-1:0] cac_inc(input logic [CAC_LINE_W-1:0] v);
    cac_inc = v + 1'b1;
  endfunction : cac_inc

  ////////////////////////////////////////////////////////////////////////////
  // trigger input: two-stage synchroniser, then edge detect
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end
    else if (i_ce)
    begin
      trig_s1 <= i_trigger_pin;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  wire trig_rise = trig_s2 && !trig_s3;

  ////////////////////////////////////////////////////////////////////////////
  // live configuration and stored slots
  // slots are flip-flops standing in for non-volatile storage; reset
  // restores them to defaults, so persistence needs an external backing store
  cac_cfg_t live;
  cac_cfg_t next_live;
  cac_cfg_t slot [CAC_SLOT_N];
  logic [CAC_SLOT_W-1:0] boot_slot;
  logic boot_pending;
  logic load_armed;
  logic [CAC_SLOT_W-1:0] armed_slot;

  wire cac_cfg_t port_cfg = '{
    mode: cac_mode_t'(i_mode),
    lut_en: i_lut_enable,
    roi_en: i_roi_enable,
    exposure: i_exposure,
    delay: i_readout_delay,
    roi_first: i_roi_first_line,
    roi_last: i_roi_last_line
  };
  wire load_cmd = i_config_slot_load_cmd && !boot_pending;
  wire load_now = load_cmd && load_armed && (armed_slot == i_config_slot_selector);

  // boot load wins over a host load, which wins over a live write
  assign next_live = boot_pending ? slot[boot_slot] :
                     load_now ? slot[i_config_slot_selector] :
                     i_cfg_write ? port_cfg : live;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      live <= CAC_CFG_RST;
      boot_pending <= 1'b1;
      boot_slot <= CAC_BOOT_SLOT_RST;
      load_armed <= 1'b0;
      armed_slot <= '0;
      for (int i = 0; i < CAC_SLOT_N; i++)
        slot[i] <= CAC_CFG_RST;
    end
    else if (i_ce)
    begin
      live <= next_live;
      boot_pending <= 1'b0;
      if (i_config_slot_store_cmd)
      begin
        slot[i_config_slot_selector] <= live;
        boot_slot <= i_default_slot;
      end
      if (load_cmd)
      begin
        load_armed <= !load_now;
        armed_slot <= i_config_slot_selector;
      end
      else if (i_config_slot_store_cmd || (armed_slot != i_config_slot_selector))
        load_armed <= 1'b0;
    end
  end
  assign o_boot_slot = boot_slot;
  assign o_load_armed = load_armed;

  ////////////////////////////////////////////////////////////////////////////
  // readout engine and strobes
  logic rd_active;
  logic rd_gap;
  logic [CAC_LINE_W-1:0] rd_line;
  logic [CAC_LINE_W-1:0] rd_pix;
  logic line_valid_strobe;
  logic line_valid_strobe_d;
  logic frame_valid_strobe;
  logic fifo_ready;
  logic rd_start;
  logic [CAC_OUT_W-1:0] lut [CAC_LUT_DEPTH];
  logic [CAC_OUT_W-1:0] push_data;

  wire line_in_roi = !live.roi_en ||
                     (rd_line >= live.roi_first && rd_line <= live.roi_last);
  wire rd_go = rd_active && !rd_gap;
  wire pix_take = rd_go && line_in_roi && fifo_ready;
  wire line_skip = rd_go && !line_in_roi;
  wire line_end = (pix_take && rd_pix == i_line_pixels - 1'b1) || line_skip;
  wire last_line = (rd_line == i_frame_lines - 1'b1);
  wire line_valid_strobe_fall = line_valid_strobe_d && !line_valid_strobe;

  // without the table the top bits pass straight through
  assign push_data = live.lut_en ? lut[i_sensor_data] :
                     i_sensor_data[CAC_PIX_W-1 -: CAC_OUT_W];
  assign o_sensor_read = pix_take;

  always_ff @(posedge i_clk)
  begin
    if (i_ce && i_lut_write)
      lut[i_lut_addr] <= i_lut_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_active <= 1'b0;
      rd_gap <= 1'b0;
      rd_line <= '0;
      rd_pix <= '0;
    end
    else if (i_ce)
    begin
      if (rd_start)
      begin
        rd_active <= 1'b1;
        rd_gap <= 1'b0;
        rd_line <= '0;
        rd_pix <= '0;
      end
      else if (rd_gap)
        rd_gap <= 1'b0;
      else if (line_end)
      begin
        // one idle cycle after a real line gives line valid a falling edge
        rd_gap <= pix_take;
        rd_pix <= '0;
        rd_active <= !last_line;
        rd_line <= cac_inc(rd_line);
      end
      else if (pix_take)
        rd_pix <= cac_inc(rd_pix);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_valid_strobe <= 1'b0;
      line_valid_strobe_d <= 1'b0;
      frame_valid_strobe <= 1'b0;
    end
    else if (i_ce)
    begin
      line_valid_strobe <= rd_go && line_in_roi;
      line_valid_strobe_d <= line_valid_strobe;
      frame_valid_strobe <= rd_active;
    end
  end
  assign o_line_valid_strobe = line_valid_strobe;
  assign o_frame_valid_strobe = frame_valid_strobe;

  cac_fifo #(
    .WIDTH(CAC_OUT_W),
    .DEPTH(CAC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(pix_take),
    .o_in_ready(fifo_ready),
    .i_in_data(push_data),
    .o_out_valid(o_pix_valid),
    .i_out_ready(i_pix_ready),
    .o_out_data(o_pix_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // exposure sequencer; timers count clock periods
  cac_state_t state;
  cac_state_t next_state;
  logic [CAC_TIME_W-1:0] tmr;
  logic [CAC_TIME_W-1:0] next_tmr;
  logic pw_run;
  logic next_pw_run;

  wire trig_mode = (live.mode == CAC_MODE_TIMED) || (live.mode == CAC_MODE_PULSE);
  wire hw_start = trig_mode && trig_rise;
  wire sw_start = trig_mode && i_soft_trigger;
  wire free_start = !trig_mode;
  wire start_req = hw_start || sw_start || free_start;
  // a software trigger has no pulse length, so it always runs timed
  wire pw_pick = (live.mode == CAC_MODE_PULSE) && hw_start && !sw_start;
  wire exp_done = pw_run ? !trig_s2 : (tmr <= 24'h000001);

  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    next_pw_run = pw_run;
    rd_start = 1'b0;
    case (state)
      CAC_ST_IDLE:
      begin
        if (start_req)
        begin
          next_pw_run = pw_pick;
          next_state = frame_valid_strobe ? CAC_ST_ALIGN : CAC_ST_LATENCY;
          next_tmr = CAC_LAT_LOAD;
        end
      end
      CAC_ST_ALIGN:
      begin
        if (line_valid_strobe_fall || !frame_valid_strobe)
        begin
          next_state = CAC_ST_EXPOSE;
          next_tmr = live.exposure;
        end
      end
      CAC_ST_LATENCY:
      begin
        next_tmr = cac_dec(tmr);
        if (tmr == '0)
        begin
          next_state = CAC_ST_EXPOSE;
          next_tmr = live.exposure;
        end
      end
      CAC_ST_EXPOSE:
      begin
        next_tmr = cac_dec(tmr);
        if (exp_done)
        begin
          next_state = CAC_ST_DELAY;
          next_tmr = live.delay;
        end
      end
      CAC_ST_DELAY:
      begin
        next_tmr = cac_dec(tmr);
        if (tmr == '0)
          next_state = CAC_ST_WAIT_RD;
      end
      CAC_ST_WAIT_RD:
      begin
        // an early trigger fall leaves readout still busy; hold here
        if (!rd_active)
        begin
          rd_start = 1'b1;
          next_state = CAC_ST_IDLE;
        end
      end
      default:
        next_state = CAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= CAC_ST_IDLE;
      tmr <= '0;
      pw_run <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      tmr <= next_tmr;
      pw_run <= next_pw_run;
    end
  end
  assign o_exposing = (state == CAC_ST_EXPOSE);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CAC_TIME_W-1:0] exp_len;
  logic [CAC_TIME_W-1:0] exp_goal;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      exp_len <= '0;
      exp_goal <= '0;
    end
    else if (i_ce)
    begin
      exp_len <= o_exposing ? exp_len + 1'b1 : '0;
      if (next_state == CAC_ST_EXPOSE && state != CAC_ST_EXPOSE)
        exp_goal <= (next_tmr == '0) ? 24'h000001 : next_tmr;
    end
  end

  default clocking cb_top @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_lut_wr;
    i_ce && i_lut_write;
  endsequence
  sequence s_idle_start;
    state == CAC_ST_IDLE && start_req && !frame_valid_strobe && i_ce;
  endsequence
  sequence s_second_load;
    i_ce && load_now && !boot_pending;
  endsequence

  a_lut_write_keep: assert property (
    s_lut_wr |=> lut[$past(i_lut_addr)] == $past(i_lut_data))
    else $error("table entry not written");
  a_lut_remap_out: assert property (
    o_sensor_read && live.lut_en |-> push_data == lut[i_sensor_data])
    else $error("pixel not taken from table");
  a_roi_line_only: assert property (
    i_ce && o_line_valid_strobe |-> $past(line_in_roi))
    else $error("line valid outside region");
  a_strobe_nesting: assert property (
    o_line_valid_strobe |-> o_frame_valid_strobe || $past(rd_active))
    else $error("line valid outside frame");
  a_timed_exp_len: assert property (
    $fell(o_exposing) && !pw_run && $past(i_ce) |-> exp_len == exp_goal)
    else $error("timed exposure length wrong");
  a_trig_idle_wait: assert property (
    state == CAC_ST_IDLE && trig_mode && !trig_rise && !i_soft_trigger && i_ce
    |=> state == CAC_ST_IDLE)
    else $error("left idle without trigger");
  a_pulse_end_exp: assert property (
    o_exposing && pw_run && !trig_s2 && i_ce |=> !o_exposing)
    else $error("pulse fall did not end exposure");
  a_align_line_fall: assert property (
    state == CAC_ST_ALIGN && line_valid_strobe_fall && i_ce |=> o_exposing)
    else $error("aligned start missed line fall");
  a_fixed_latency: assert property (
    s_idle_start ##1 i_ce [*2] |=> o_exposing)
    else $error("start latency wrong");
  a_soft_trig_go: assert property (
    state == CAC_ST_IDLE && trig_mode && i_soft_trigger && i_ce |=> state != CAC_ST_IDLE)
    else $error("software trigger ignored");
  a_delay_to_read: assert property (
    state == CAC_ST_DELAY && tmr == '0 && i_ce |=> state == CAC_ST_WAIT_RD)
    else $error("readout delay wrong");
  a_boot_load_slot: assert property (
    boot_pending && i_ce |=> live == slot[boot_slot])
    else $error("power-up slot not loaded");
  a_slot_load_twice: assert property (
    s_second_load |=> live == slot[$past(i_config_slot_selector)])
    else $error("second load did not apply slot");
  a_slot_store_live: assert property (
    i_ce && i_config_slot_store_cmd |=> slot[$past(i_config_slot_selector)] == $past(live))
    else $error("store did not capture live settings");
endmodule : cac_top
`default_nettype wire

// ==== verification/cac_trig_src.sv ====
// cac_trig_src: external trigger source model for the acquisition controller.
// assumes the bench clock; frame valid is watched before the pin falls.
`default_nettype none
module cac_trig_src (
  input wire logic i_clk,
  input wire logic i_frame_valid,
  output var logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_pin = 1'b0;

  // pin high for at least width+1 cycles; the fall waits for readout to end
  task automatic pulse(input int width, output logic late);
    int k;
    @(posedge i_clk);
    o_pin <= 1'b1;
    repeat (width) @(posedge i_clk);
    k = 0;
    // sampled mid-cycle so the frame strobe is settled
    while (i_frame_valid !== 1'b0 && k < 5000)
    begin
      @(negedge i_clk);
      k++;
    end
    // a frame that never ends is reported back rather than hanging here
    late = (k >= 5000);
    @(posedge i_clk);
    o_pin <= 1'b0;
  endtask : pulse
endmodule : cac_trig_src
`default_nettype wire

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the acquisition controller.
// assumes cac_pkg and cac_trig_src are compiled first; one 10 MHz clock.
`default_nettype none
module tb_top
  import cac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ready = 1'b1;
  logic ce = 1'b1;
  logic [CAC_LINE_W-1:0] roi_f = 12'h001, roi_l = 12'h001;
  logic lute = 1'b0, roie = 1'b0, lut_on = 1'b0, lutw = 1'b0, line_valid_strobe_q = 1'b0;
  logic [3:0] cmds = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [CAC_TIME_W-1:0] expo_v = 24'h000000, dly = 24'h000000;
  logic [CAC_PIX_W-1:0] lut_a = 12'h000;
  logic [CAC_OUT_W-1:0] lut_d = 8'h00;
  logic [CAC_SLOT_W-1:0] sel = 3'h0, dflt = 3'h0;
  logic pin, srd, expg, line_valid_strobe, frame_valid_strobe, pv, armed;
  logic [CAC_OUT_W-1:0] pd;
  logic [CAC_SLOT_W-1:0] boot;
  logic [1:0] mon;
  logic [5:0] lf_hist = 6'h00;
  logic [CAC_OUT_W-1:0] q[$];
  int reads = 0, lv_cnt = 0, mismatches = 0, n_compared = 0;
  assign mon = {frame_valid_strobe, expg};

  // geometry fixed small: 3 lines of 4 pixels, region is line 1 only
  cac_top dut_u (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_ce(ce),
    .i_trigger_pin(pin),
    .i_soft_trigger(cmds[0]),
    .i_cfg_write(cmds[3]),
    .i_mode(mode),
    .i_lut_enable(lute),
    .i_roi_enable(roie),
    .i_exposure(expo_v),
    .i_readout_delay(dly),
    .i_roi_first_line(roi_f),
    .i_roi_last_line(roi_l),
    .i_line_pixels(12'h004),
    .i_frame_lines(12'h003),
    .i_lut_write(lutw),
    .i_lut_addr(lut_a),
    .i_lut_data(lut_d),
    .i_config_slot_selector(sel),
    .i_config_slot_load_cmd(cmds[1]),
    .i_config_slot_store_cmd(cmds[2]),
    .i_default_slot(dflt),
    .i_sensor_data({reads[5:0], ~reads[5:0]}),
    .o_sensor_read(srd),
    .o_exposing(expg),
    .o_line_valid_strobe(line_valid_strobe),
    .o_frame_valid_strobe(frame_valid_strobe),
    .o_pix_valid(pv),
    .i_pix_ready(ready),
    .o_pix_data(pd),
    .o_boot_slot(boot),
    .o_load_armed(armed)
  );

  cac_trig_src trig_u (
    .i_clk(clk),
    .i_frame_valid(frame_valid_strobe),
    .o_pin(pin)
  );

  ////////////////////////////////////////////////////////////
  initial
  begin
    forever #50 clk = ~clk;
  end

  // non-monotonic curve so a plain bit slice cannot pass for it
  function automatic logic [7:0] tbl(input logic [5:0] k);
    return 8'({2'b00, k} * 8'h05) ^ 8'h3c;
  endfunction : tbl

  always @(posedge clk)
  begin
    line_valid_strobe_q <= line_valid_strobe;
    lf_hist <= {lf_hist[4:0], line_valid_strobe_q & ~line_valid_strobe};
    if (line_valid_strobe === 1'b1)
      lv_cnt <= lv_cnt + 1;
    if (pv === 1'b1 && ready === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(32'(pd), 32'(q.pop_front()));
    end
    if (srd === 1'b1)
    begin
      q.push_back(lut_on ? tbl(reads[5:0]) : {reads[5:0], ~reads[5:4]});
      reads <= reads + 1;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic wait_mon(input int b, input logic v, output int n);
    n = 0;
    while (mon[b] !== v && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask : wait_mon

  task automatic cmd(input logic [3:0] c);
    @(posedge clk);
    cmds <= c;
    @(posedge clk);
    cmds <= 4'h0;
    #1;
  endtask : cmd

  task automatic cfg(input logic [1:0] m, input logic l, r, input int e, d);
    @(posedge clk);
    mode <= m;
    lute <= l;
    roie <= r;
    expo_v <= CAC_TIME_W'(e);
    dly <= CAC_TIME_W'(d);
    cmd(4'h8);
  endtask : cfg

  task automatic expo(output int n);
    wait_mon(0, 1'b1, n);
    wait_mon(0, 1'b0, n);
  endtask : expo

  // expected data follows the table flag only once readout is quiet
  task automatic idle();
    int n;
    wait_mon(1, 1'b0, n);
    wait_mon(0, 1'b0, n);
    repeat (40) @(posedge clk);
    #1;
    lut_on = lute;
  endtask : idle

  ////////////////////////////////////////////////////////////
  task automatic t_free();
    int n;
    expo(n);
    check(n, CAC_EXPOSURE_RST);
    wait_mon(1, 1'b1, n);
    wait_mon(1, 1'b0, n);
    wait_mon(1, 1'b1, n);
    check(32'(frame_valid_strobe), 32'h1);
    $display("t_free done");
  endtask : t_free

  task automatic t_roi();
    int n, r0, l0;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk);
      lutw <= 1'b1;
      lut_a <= {k[5:0], ~k[5:0]};
      lut_d <= tbl(k[5:0]);
    end
    @(posedge clk);
    lutw <= 1'b0;
    cfg(2'(CAC_MODE_TIMED), 1'b0, 1'b0, 3, 5);
    idle();
    cfg(2'(CAC_MODE_TIMED), 1'b1, 1'b1, 3, 5);
    idle();
    check(32'(expg), 32'h0);
    r0 = reads;
    l0 = lv_cnt;
    cmd(4'h1);
    wait_mon(0, 1'b1, n);
    check(n, CAC_START_LAT_CYC);
    wait_mon(0, 1'b0, n);
    check(n, 3);
    wait_mon(1, 1'b1, n);
    check(n, 8);
    idle();
    check(reads - r0, 4);
    check(lv_cnt - l0, 4);
    $display("t_roi done");
  endtask : t_roi

  task automatic t_stall();
    int r0;
    cfg(2'(CAC_MODE_TIMED), 1'b0, 1'b0, 3, 0);
    idle();
    @(posedge clk);
    ready <= 1'b0;
    r0 = reads;
    cmd(4'h1);
    repeat (80) @(posedge clk);
    #1;
    check(reads - r0, CAC_FIFO_DEPTH);
    check(32'(pv), 32'h1);
    @(posedge clk);
    ready <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    check(reads - r0, 12);
    check(q.size(), 0);
    check(32'(pv), 32'h0);
    $display("t_stall done");
  endtask : t_stall

  task automatic t_pulse();
    int n1, n2;
    logic late;
    cfg(2'(CAC_MODE_PULSE), 1'b0, 1'b0, 3, 0);
    idle();
    fork
      trig_u.pulse(10, late);
      expo(n1);
    join
    check(32'(late), 32'h0);
    idle();
    fork
      trig_u.pulse(25, late);
      expo(n2);
    join
    check(32'(late), 32'h0);
    check(n2 - n1, 15);
    wait_mon(1, 1'b1, n1);
    fork
      trig_u.pulse(3, late);
      begin
        wait_mon(0, 1'b1, n1);
        // exposure must open on the very edge that sees line valid fall
        check(32'(lf_hist[0]), 32'h1);
      end
    join
    check(32'(late), 32'h0);
    idle();
    $display("t_pulse done");
  endtask : t_pulse

  task automatic t_slots();
    int n;
    cfg(2'(CAC_MODE_TIMED), 1'b0, 1'b0, 4, 0);
    @(posedge clk);
    sel <= 3'h3;
    dflt <= 3'h3;
    cmd(4'h4);
    check(32'(boot), 32'h3);
    cfg(2'(CAC_MODE_TIMED), 1'b0, 1'b0, 9, 0);
    cmd(4'h2);
    check(32'(armed), 32'h1);
    cmd(4'h1);
    expo(n);
    check(n, 9);
    idle();
    cmd(4'h2);
    check(32'(armed), 32'h0);
    cmd(4'h1);
    expo(n);
    check(n, 4);
    idle();
    // clock enable low must hold the exposure timer: one cycle runs before
    // the freeze, the remaining three after it
    cmd(4'h1);
    wait_mon(0, 1'b1, n);
    @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(32'(expg), 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    wait_mon(0, 1'b0, n);
    check(n, 3);
    idle();
    q.delete();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(32'(boot), 32'h0);
    expo(n);
    check(n, CAC_EXPOSURE_RST);
    $display("t_slots done");
  endtask : t_slots

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_free();
    t_roi();
    t_stall();
    t_pulse();
    t_slots();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
